// ### hdl/pph_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PPH_DEFS_SVH
`define PPH_DEFS_SVH
`define PPH_A_GEN 6'h00
`define PPH_A_ACTL 6'h04
`define PPH_A_BCTL 6'h08
`define PPH_A_DIRA 6'h0c
`define PPH_A_DIRB 6'h10
`define PPH_A_DATA 6'h14
`define PPH_A_DATB 6'h18
`define PPH_A_STAT 6'h1c
`define PPH_G_OUTEN 0
`define PPH_G_INEN 1
`define PPH_G_BIDIR 2
`define PPH_C_STAT 0
`define PPH_C_SVC 1
`define PPH_C_IRQ 2
`define PPH_C_PULSE 3
`define PPH_C_HS 4
`define PPH_C_OUT 5
`define PPH_CR_RST 8'h00
`define PPH_GEN_RST 3'h0
`define PPH_ROLE_LOW 3'h4
`define PPH_ROLE_HIGH 3'h5
`define PPH_S_ACC 0
`define PPH_S_RDY 1
`define PPH_S_STB 2
`define PPH_S_RPL 3
`define PPH_L_ACC 0
`define PPH_L_RDY 1
`define PPH_L_STB 2
`define PPH_L_RPL 3
`define PPH_OUT_DLY 2'h2
`define PPH_IN_DLY 2'h1
`define PPH_PULSE 3'h4
`endif

// ### hdl/pph_pkg.sv
// Types shared by the parallel port handshake block.
package pph_pkg;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [5:0] adr;
      logic [31:0] dat;
   } pph_wb_req_t;
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
   } pph_sync_st_t;
   typedef struct packed {
      logic [1:0][15:0] mem;
      logic rp;
      logic wp;
      logic [1:0] cnt;
      logic armed;
      logic [1:0] wt;
      logic [2:0] pc;
   } pph_chan_st_t;
   typedef struct packed {
      logic [2:0] gen;
      logic [7:0] actl;
      logic [7:0] bctl;
      logic [7:0] dira;
      logic [7:0] dirb;
      logic [7:0] fola;
      logic [7:0] tmp;
      logic [7:0] inhead;
      logic acc_f;
      logic rdy_f;
      logic rpl_f;
      logic st;
      logic ack;
      logic [31:0] rdat;
      logic [7:0] pa_o;
      logic [7:0] pb_o;
      logic [7:0] pa_oe_n;
      logic [7:0] pb_oe_n;
      logic rdy_o;
      logic rdy_oe_n;
      logic rpl_o;
      logic rpl_oe_n;
      logic dma;
      logic svc;
   } pph_top_st_t;
endpackage

// ### hdl/pph_sync.sv
// Two-stage synchroniser and rising-edge detector for the four handshake lines.
`timescale 1ns/1ps
`include "pph_defs.svh"
module pph_sync
   import pph_pkg::*;
(
   input wire logic clk_i, // Device clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic [3:0] line_i, // Raw handshake line levels.
   output logic [3:0] lvl_o, // Synchronised levels.
   output logic [3:0] rise_o // One-cycle asserted-edge pulses.
);
   pph_sync_st_t q;
   pph_sync_st_t d;

   // Stage one feeds only stage two, so no logic sees a metastable value.
   always_comb begin
      d = q;
      d.s1 = line_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lvl_o = q.s2;

   // One detector per line.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_edge
         assign rise_o[g] = q.s2[g] && !q.s3[g];
      end
   endgenerate
endmodule

// ### hdl/pph_chan.sv
// Two-entry double buffer with its interlocked or pulsed handshake line.
`timescale 1ns/1ps
`include "pph_defs.svh"
module pph_chan
   import pph_pkg::*;
#(
   parameter bit OUT_DIR = 1'b1,
   parameter logic [1:0] DLY = `PPH_OUT_DLY
) (
   input wire logic clk_i, // Device clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic push_i, // Host push (output direction only).
   input wire logic pop_i, // Host pop (input direction only).
   input wire logic [15:0] data_i, // Word to store.
   input wire logic edge_i, // Partner strobe edge, synchronised.
   input wire logic en_i, // Handshake pair enable.
   input wire logic pulsed_i, // Pulsed rather than interlocked.
   output logic [15:0] head_o, // Next head entry.
   output logic [1:0] cnt_o, // Next fill count.
   output logic line_o // Next handshake line level.
);
   pph_chan_st_t q;
   pph_chan_st_t d;
   logic take;
   logic psh;
   logic pop;
   logic ready;

   // A partner edge counts only while the line is armed; others are dropped.
   always_comb begin
      d = q;
      take = edge_i && q.armed && en_i;
      psh = (OUT_DIR ? push_i : take) && (q.cnt != 2'h2);
      pop = (OUT_DIR ? take : pop_i) && (q.cnt != 2'h0);
      if (psh) begin
         d.mem[q.wp] = data_i;
         d.wp = !q.wp;
      end
      if (pop) begin
         d.rp = !q.rp;
      end
      d.cnt = 2'(q.cnt + {1'b0, psh} - {1'b0, pop});
      ready = OUT_DIR ? (q.cnt != 2'h0) : (q.cnt != 2'h2);
      if (!en_i) begin
         d.armed = 1'b0;
         d.wt = 2'h0;
         d.pc = 3'h0;
      end else if (take) begin
         d.armed = 1'b0;
         d.wt = 2'h0;
      end else if (!q.armed && ready) begin
         if (q.wt == 2'(DLY - 2'h1)) begin
            d.armed = 1'b1;
            d.pc = 3'h0;
         end else begin
            d.wt = 2'(q.wt + 2'h1);
         end
      end else if (q.armed && q.pc != `PPH_PULSE) begin
         d.pc = 3'(q.pc + 3'h1);
      end
      head_o = d.mem[d.rp];
      cnt_o = d.cnt;
      line_o = d.armed && (!pulsed_i || d.pc < `PPH_PULSE);
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Latch filled from empty while enabled.
   sequence s_fill;
      en_i && q.cnt == 2'h0 ##1 en_i && q.cnt != 2'h0 && !q.armed;
   endsequence

   AST_ARM_DELAY: assert property (
      OUT_DIR && en_i ##0 s_fill ##1 (en_i && !edge_i) |-> !q.armed ##1 q.armed)
      else $error("Output line did not arm two cycles after the latch filled.");

   AST_EDGE_IGNORED: assert property (
      OUT_DIR && edge_i && !q.armed && !push_i |=> $stable(q.cnt))
      else $error("Strobe edge changed the output path while the line was negated.");

   AST_IN_IGNORED: assert property (
      !OUT_DIR && edge_i && !q.armed && !pop_i |=> $stable(q.cnt))
      else $error("Strobe edge captured data while the line was negated.");
endmodule

// ### hdl/pph_top.sv
// Parallel port handshake block with its classic Wishbone register slave.
// Notes on behaviour
// - Reply line control field picks status input, low, high, interlocked or pulsed.
// - Port A byte waits in a temp latch; port B write moves 16 bits.
// - DMA request asks for another word when the output path has room; in bidirectional mode, when input data waits.
// - Reply edge sets its flag; reset, write-one or pair disable clear it.
// - Interlocked output: reply asserts two cycles after a load, drops on strobe.
// - Next word loads after an acknowledge; strobes while negated are ignored.
// - Pulsed output: reply asserts like interlocked, at most four cycles.
// - In handshake roles the reply flag reads zero; pair disable negates line.
// - Strobe flag means room in a latch, or both empty when bit 0 set.
// - Ready line field picks status input or fixed output; flag kept clear as output.
// - Input-direction pins keep buffered data but never drive.
// - Every accept edge sets its flag, whatever port A bit 0 holds.
// - Bits 2 and 1 of each control register gate their service requests.
// - Bidirectional mode: port A bit I/O, port B double-buffered both ways.
// - Accept level enables port B drivers when negated, disables when asserted.
// - Port A single-buffered; reads give pin for inputs, latch for outputs.
// - Strobe edge while reply asserted captures port B data; flag shows unread data.
// - Interlocked input: reply asserts while room, drops on strobe, ignores strays.
// - Pulsed input: reply asserts like interlocked, at most four cycles.
// - Control registers clear on reset; reading them has no side effect.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "pph_defs.svh"
module pph_top
   import pph_pkg::*;
(
   input wire logic clk_i, // 25 MHz device clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire pph_wb_req_t wb_i, // Wishbone request group.
   output logic wb_ack_o, // Wishbone acknowledge.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   input wire logic [7:0] pa_i, // Port A pin levels.
   output logic [7:0] pa_o, // Port A pin drive.
   output logic [7:0] pa_oe_n_o, // Port A enable, low drives.
   input wire logic [7:0] pb_i, // Port B pin levels.
   output logic [7:0] pb_o, // Port B pin drive.
   output logic [7:0] pb_oe_n_o, // Port B enable, low drives.
   input wire logic accept_i, // Output accept input line.
   input wire logic strobe_i, // Input strobe line.
   input wire logic ready_i, // Output ready line, input side.
   output logic ready_o, // Output ready line drive.
   output logic ready_oe_n_o, // Ready line enable, low drives.
   input wire logic reply_i, // Reply line, input side.
   output logic reply_o, // Reply line drive.
   output logic reply_oe_n_o, // Reply line enable, low drives.
   output logic dma_req_o, // DMA request, active high.
   output logic svc_req_o // Service request, active high.
);
   localparam pph_top_st_t TOP_RST = '{
      pa_oe_n: 8'hff,
      pb_oe_n: 8'hff,
      rdy_oe_n: 1'b1,
      rpl_oe_n: 1'b1,
      default: '0
   };

   pph_top_st_t q;
   pph_top_st_t d;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic acc;
   logic wr;
   logic rd;
   logic wr_b;
   logic bidir;
   logic nbidir;
   logic [3:0] clr;
   logic o_push;
   logic [15:0] o_data;
   logic o_edge;
   logic o_en;
   logic o_pulsed;
   logic [15:0] o_head;
   logic [1:0] o_cnt;
   logic o_line;
   logic i_pop;
   logic i_en;
   logic [15:0] i_head;
   logic [1:0] i_cnt;
   logic i_line;
   logic rpl_hs;

   // Edge detection for accept, ready, strobe and reply, in that order.
   pph_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .line_i({reply_i, strobe_i, ready_i, accept_i}),
      .lvl_o(lvl),
      .rise_o(rise)
   );

   // Output path: 16-bit words, or port B bytes in bidirectional mode.
   pph_chan #(.OUT_DIR(1'b1), .DLY(`PPH_OUT_DLY)) u_out (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(o_push),
      .pop_i(1'b0),
      .data_i(o_data),
      .edge_i(o_edge),
      .en_i(o_en),
      .pulsed_i(o_pulsed),
      .head_o(o_head),
      .cnt_o(o_cnt),
      .line_o(o_line)
   );

   // Input path, used only in bidirectional mode.
   pph_chan #(.OUT_DIR(1'b0), .DLY(`PPH_IN_DLY)) u_in (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(1'b0),
      .pop_i(i_pop),
      .data_i({8'h00, pb_i}),
      .edge_i(rise[`PPH_L_STB]),
      .en_i(i_en),
      .pulsed_i(q.bctl[`PPH_C_PULSE]),
      .head_o(i_head),
      .cnt_o(i_cnt),
      .line_o(i_line)
   );

   // Bus decode; a request is taken once, on the cycle before ack rises.
   always_comb begin
      acc = wb_i.cyc && wb_i.stb && !q.ack;
      wr = acc && wb_i.we && wb_i.sel[0];
      rd = acc && !wb_i.we;
      wr_b = wr && wb_i.adr == `PPH_A_DATB;
      bidir = q.gen[`PPH_G_BIDIR];
   end

   // Steering of both paths; the mode picks which strobe acknowledges output.
   always_comb begin
      o_push = wr_b;
      o_data = bidir ? {8'h00, wb_i.dat[7:0]} : {q.tmp, wb_i.dat[7:0]};
      o_edge = bidir ? rise[`PPH_L_ACC] : rise[`PPH_L_STB];
      o_en = bidir ? q.gen[`PPH_G_OUTEN]
                   : q.gen[`PPH_G_INEN] && q.bctl[`PPH_C_OUT] && q.bctl[`PPH_C_HS];
      o_pulsed = bidir ? q.actl[`PPH_C_PULSE] : q.bctl[`PPH_C_PULSE];
      i_pop = rd && bidir && wb_i.adr == `PPH_A_DATB;
      i_en = bidir && q.gen[`PPH_G_INEN];
   end

   // Next state: register writes first, then flags and pins from new values.
   always_comb begin
      d = q;
      d.ack = acc;
      d.rdat = 32'h0000_0000;
      clr = 4'h0;
      if (wr) begin
         case (wb_i.adr)
            `PPH_A_GEN: begin
               d.gen = wb_i.dat[2:0];
            end
            `PPH_A_ACTL: begin
               d.actl = wb_i.dat[7:0];
            end
            `PPH_A_BCTL: begin
               d.bctl = wb_i.dat[7:0];
            end
            `PPH_A_DIRA: begin
               d.dira = wb_i.dat[7:0];
            end
            `PPH_A_DIRB: begin
               d.dirb = wb_i.dat[7:0];
            end
            `PPH_A_DATA: begin
               if (bidir) begin
                  d.fola = wb_i.dat[7:0];
               end else begin
                  d.tmp = wb_i.dat[7:0];
               end
            end
            `PPH_A_STAT: begin
               clr = wb_i.dat[3:0];
            end
            default: begin
            end
         endcase
      end
      // Reads only select; only the port B input pop has an effect.
      if (rd) begin
         case (wb_i.adr)
            `PPH_A_GEN: begin
               d.rdat = {29'h0, q.gen};
            end
            `PPH_A_ACTL: begin
               d.rdat = {24'h0, q.actl};
            end
            `PPH_A_BCTL: begin
               d.rdat = {24'h0, q.bctl};
            end
            `PPH_A_DIRA: begin
               d.rdat = {24'h0, q.dira};
            end
            `PPH_A_DIRB: begin
               d.rdat = {24'h0, q.dirb};
            end
            `PPH_A_DATA: begin
               d.rdat = {24'h0, (pa_i & ~q.dira) | (q.pa_o & q.dira)};
            end
            `PPH_A_DATB: begin
               d.rdat = bidir ? {24'h0, q.inhead}
                              : {24'h0, (pb_i & ~q.dirb) | (q.pb_o & q.dirb)};
            end
            `PPH_A_STAT: begin
               d.rdat = {28'h0, q.rpl_f, q.st, q.rdy_f, q.acc_f};
            end
            default: begin
               d.rdat = 32'h0000_0000;
            end
         endcase
      end
      nbidir = !d.gen[`PPH_G_BIDIR];
      // Hardware set wins over a write-one clear in the same cycle.
      d.acc_f = rise[`PPH_L_ACC] || (q.acc_f && !clr[`PPH_S_ACC]);
      d.rdy_f = d.gen[`PPH_G_OUTEN] && nbidir && !d.actl[`PPH_C_OUT]
                && (rise[`PPH_L_RDY] || (q.rdy_f && !clr[`PPH_S_RDY]));
      d.rpl_f = d.gen[`PPH_G_INEN] && nbidir && !d.bctl[`PPH_C_OUT]
                && (rise[`PPH_L_RPL] || (q.rpl_f && !clr[`PPH_S_RPL]));
      // Strobe status follows the path that this mode uses.
      if (!nbidir) begin
         d.st = i_cnt != 2'h0;
      end else if (d.bctl[`PPH_C_STAT]) begin
         d.st = o_cnt == 2'h0;
      end else begin
         d.st = o_cnt != 2'h2;
      end
      d.inhead = i_head[7:0];
      d.dma = d.bctl[`PPH_C_SVC] && d.st;
      d.svc = (d.acc_f && d.actl[`PPH_C_SVC]) || (d.rdy_f && d.actl[`PPH_C_IRQ])
              || (d.st && d.bctl[`PPH_C_SVC]) || (d.rpl_f && d.bctl[`PPH_C_IRQ]);
      // Port pins; direction bits of port B are ignored in bidirectional mode.
      d.pa_o = nbidir ? o_head[15:8] : d.fola;
      d.pb_o = o_head[7:0];
      d.pa_oe_n = ~d.dira;
      // Relies on the peripheral asserting accept before it drives port B.
      d.pb_oe_n = nbidir ? ~d.dirb : {8{lvl[`PPH_L_ACC]}};
      // Ready line role.
      if (!nbidir) begin
         d.rdy_o = o_line;
         d.rdy_oe_n = 1'b0;
      end else if (d.actl[`PPH_C_OUT]) begin
         d.rdy_o = d.actl[`PPH_C_PULSE];
         d.rdy_oe_n = 1'b0;
      end else begin
         d.rdy_o = 1'b0;
         d.rdy_oe_n = 1'b1;
      end
      // Reply line role.
      if (!nbidir) begin
         d.rpl_o = i_line;
         d.rpl_oe_n = 1'b0;
      end else if (!d.bctl[`PPH_C_OUT]) begin
         d.rpl_o = 1'b0;
         d.rpl_oe_n = 1'b1;
      end else if (d.bctl[`PPH_C_HS]) begin
         d.rpl_o = o_line;
         d.rpl_oe_n = 1'b0;
      end else begin
         d.rpl_o = d.bctl[`PPH_C_PULSE];
         d.rpl_oe_n = 1'b0;
      end
   end

   // State register; control fields clear on reset and pins float.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= TOP_RST;
      end else begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign pa_o = q.pa_o;
   assign pa_oe_n_o = q.pa_oe_n;
   assign pb_o = q.pb_o;
   assign pb_oe_n_o = q.pb_oe_n;
   assign ready_o = q.rdy_o;
   assign ready_oe_n_o = q.rdy_oe_n;
   assign reply_o = q.rpl_o;
   assign reply_oe_n_o = q.rpl_oe_n;
   assign dma_req_o = q.dma;
   assign svc_req_o = q.svc;

   assign rpl_hs = bidir || (q.bctl[`PPH_C_OUT] && q.bctl[`PPH_C_HS]);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ROLE_LOW: assert property (
      !bidir && q.bctl[5:3] == `PPH_ROLE_LOW |-> !reply_o && !reply_oe_n_o)
      else $error("Reply line not held negated in its low output role.");

   AST_DMA_GATE: assert property (
      dma_req_o |-> q.bctl[`PPH_C_SVC] && q.st)
      else $error("DMA request raised without room or without its enable.");

   AST_RPL_FLAG_EN: assert property (
      !q.gen[`PPH_G_INEN] |-> !q.rpl_f)
      else $error("Reply flag set while the input pair is disabled.");

   AST_RPL_PULSE: assert property (
      (reply_o && rpl_hs && q.bctl[`PPH_C_PULSE])[*4] |=> !reply_o)
      else $error("Pulsed reply line stayed asserted beyond four cycles.");

   AST_RPL_FLAG_ROLE: assert property (
      bidir || q.bctl[`PPH_C_OUT] |-> !q.rpl_f)
      else $error("Reply flag reads set while the line is an output.");

   AST_RDY_FLAG: assert property (
      bidir || q.actl[`PPH_C_OUT] || !q.gen[`PPH_G_OUTEN] |-> !q.rdy_f)
      else $error("Ready flag set while the line is not a status input.");

   AST_ACC_EDGE: assert property (
      rise[`PPH_L_ACC] |=> q.acc_f)
      else $error("Accept edge did not set its flag.");

   AST_SVC_GATE: assert property (
      q.rpl_f && q.bctl[`PPH_C_IRQ] |-> svc_req_o)
      else $error("Enabled reply flag did not raise a service request.");

   AST_PB_DRIVE: assert property (
      bidir && $past(lvl[`PPH_L_ACC]) |-> pb_oe_n_o == 8'hff)
      else $error("Port B driven while accept was asserted.");

   AST_CTRL_RESET: assert property (
      $past(rst_i) |-> q.actl == `PPH_CR_RST && q.bctl == `PPH_CR_RST)
      else $error("Control registers not cleared by reset.");
endmodule

// ### dv/pph_peer.sv
// Peripheral model that answers the reply line with a strobe pulse.
`timescale 1ns/1ps
module pph_peer (
   input wire logic clk_i, // Device clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic go_i, // Answer reply lines when high.
   input wire logic reply_i, // Resolved reply line level.
   output logic strobe_o, // Input strobe line.
   output logic accept_o, // Output accept input line.
   output logic [7:0] pb_o // Port B pin drive of the peripheral.
);
   logic [3:0] c_q;
   // A reply starts a cycle count; the strobe is held four cycles so the
   // synchroniser cannot miss it, and the count wraps to zero after sixteen cycles whatever the line does.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c_q <= 4'h0;
         strobe_o <= 1'b0;
      end else begin
         if (c_q != 4'h0 || (reply_i && go_i)) begin
            c_q <= c_q + 4'h1;
         end
         strobe_o <= (c_q >= 4'h3) && (c_q < 4'h7);
      end
   end
   // Accept stays negated so port B drivers stay on; data follows the cycle count.
   assign accept_o = 1'b0;
   assign pb_o = {c_q, ~c_q};
endmodule

// ### dv/pph_top_tb.sv
// Self-checking bench for the parallel port handshake block.
`timescale 1ns/1ps
`include "pph_defs.svh"
module pph_top_tb;
   import pph_pkg::*;
   logic clk_i, rst_i, wb_ack_o, ready_o, ready_oe_n_o, reply_o, reply_oe_n_o;
   logic dma_req_o, svc_req_o, accept_i, strobe_i, rpl_tb, go;
   logic [31:0] wb_dat_o, q;
   logic [7:0] pa_o, pa_oe_n_o, pb_o, pb_oe_n_o, pa_ext, pb_ext;
   pph_wb_req_t wb_i;
   integer errors, n_tests;
   // Pins resolve from the block's enables alone; ready has a pull-down.
   wire logic [7:0] pa_i = (pa_oe_n_o & pa_ext) | (~pa_oe_n_o & pa_o);
   wire logic [7:0] pb_i = (pb_oe_n_o & pb_ext) | (~pb_oe_n_o & pb_o);
   wire logic reply_i = reply_oe_n_o ? rpl_tb : reply_o;
   wire logic ready_i = ready_oe_n_o ? 1'b0 : ready_o;
   pph_top pph_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .pa_i(pa_i), .pa_o(pa_o), .pa_oe_n_o(pa_oe_n_o), .pb_i(pb_i),
      .pb_o(pb_o), .pb_oe_n_o(pb_oe_n_o), .accept_i(accept_i), .strobe_i(strobe_i),
      .ready_i(ready_i), .ready_o(ready_o), .ready_oe_n_o(ready_oe_n_o), .reply_i(reply_i),
      .reply_o(reply_o), .reply_oe_n_o(reply_oe_n_o), .dma_req_o(dma_req_o),
      .svc_req_o(svc_req_o));
   pph_peer pph_peer_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .reply_i(reply_i),
      .strobe_o(strobe_i), .accept_o(accept_i), .pb_o(pb_ext));
   // Free-running 25 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One classic cycle; the request holds until ack is seen, then one idle cycle.
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      integer i;
      wb_i <= '{1'b1, 1'b1, w, 4'hf, a, d};
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      q = wb_dat_o;
      wb_i <= '0;
      if (i >= 20) begin
         errors++;
         final_report();
      end
      @(posedge clk_i);
   endtask
   task automatic t_reset;
      wb(1'b0, `PPH_A_ACTL, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, `PPH_A_BCTL, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, `PPH_A_ACTL, 32'h5a);
      wb(1'b0, `PPH_A_ACTL, 32'h0);
      wb(1'b0, `PPH_A_ACTL, 32'h0);
      chk(q, 32'h5a);
      wb(1'b1, 6'h24, 32'hff);
      chk(q, 32'h0);
      $display("reset test done");
   endtask
   // Word leaves as {A,B}; reply rises two cycles after the push and falls on strobe.
   task automatic t_out;
      integer i;
      go <= 1'b1;
      wb(1'b1, `PPH_A_GEN, 32'h3);
      wb(1'b1, `PPH_A_DIRA, 32'hff);
      wb(1'b1, `PPH_A_DIRB, 32'h0f);
      wb(1'b1, `PPH_A_BCTL, 32'h30);
      wb(1'b1, `PPH_A_DATA, 32'ha5);
      wb(1'b1, `PPH_A_DATB, 32'h3c);
      // The task returns two edges after the push, when the reply has just risen.
      #1;
      chk(reply_o, 1'b1);
      @(posedge clk_i);
      #1;
      chk(reply_o, 1'b1);
      chk({pa_o, pb_o}, 16'ha53c);
      chk(pb_oe_n_o, 8'hf0);
      i = 0;
      while (reply_o !== 1'b0 && i < 20) begin
         @(posedge clk_i);
         i++;
      end
      chk(i < 20, 1'b1);
      @(posedge clk_i);
      wb(1'b0, `PPH_A_STAT, 32'h0);
      chk(q & 32'hc, 32'h4);
      go <= 1'b0;
      $display("output test done");
   endtask
   // Reply as a status input: edge sets the flag, writing one clears it.
   task automatic t_flag;
      wb(1'b1, `PPH_A_BCTL, 32'h00);
      rpl_tb <= 1'b1;
      repeat (5) @(posedge clk_i);
      wb(1'b0, `PPH_A_STAT, 32'h0);
      chk(q & 32'h8, 32'h8);
      wb(1'b1, `PPH_A_STAT, 32'h8);
      wb(1'b0, `PPH_A_STAT, 32'h0);
      chk(q & 32'h8, 32'h0);
      rpl_tb <= 1'b0;
      $display("flag test done");
   endtask
   // Port A bit I/O: outputs read back the latch, inputs the live pin.
   task automatic t_bidir;
      pa_ext <= 8'ha5;
      wb(1'b1, `PPH_A_GEN, 32'h5);
      wb(1'b1, `PPH_A_DIRA, 32'h0f);
      wb(1'b1, `PPH_A_DATA, 32'h3c);
      wb(1'b0, `PPH_A_DATA, 32'h0);
      chk(q, 32'hac);
      chk(pa_oe_n_o, 8'hf0);
      repeat (4) @(posedge clk_i);
      chk(pb_oe_n_o, 8'h00);
      $display("bidir test done");
   endtask
   // Main sequence.
   initial begin
      errors = 0;
      n_tests = 0;
      rst_i = 1'b1;
      wb_i = '0;
      rpl_tb = 1'b0;
      go = 1'b0;
      pa_ext = 8'h00;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_out();
      t_flag();
      t_bidir();
      final_report();
   end
endmodule
